// [verilog/pmx_pkg.sv]
// package: constants for the port 7 output select and debug entry block
package pmx_pkg;
  localparam int SEL_W = 4;
  // output-select field: bit 3 set marks output mode, bit 2 ignored, bits 1:0 pick the source
  localparam int SEL_OUT_BIT = 3;
  localparam int SEL_SRC_HI = 1;
  localparam int SEL_SRC_LO = 0;
  localparam logic [1:0] SRC_GPIO = 2'h0;
  localparam logic [1:0] SRC_ALT1 = 2'h1;
  localparam logic [1:0] SRC_ALT2 = 2'h2;
  localparam logic [1:0] SRC_ALT3 = 2'h3;
  localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;
  localparam int NPIN = 3;
  typedef enum logic [1:0] {PMX_IDX_B0, PMX_IDX_B2, PMX_IDX_B3} pmx_idx_t;
endpackage : pmx_pkg

// [verilog/pmx_port7_mux.sv]
// port 7 bits 0, 2, 3 output multiplexer with debug entry capture
//
// How it works
// - each pin's 4-bit select field 1x00, 1x01 ... picks its driven source.
// - hardware-owned debug outputs override the software select field.
// - bit0 sources: port bit, timer3 toggle, timer6 toggle; debug data out owned.
// - bit2 sources: port bit, analog mux line 0; also debug data input.
// - bit3 sources: port bit, analog mux 1, serial ch1, ch0 data out.
// - test reset level at power-on reset release decides debug activation.
`timescale 1ns/100ps
module pmx_port7_mux
  import pmx_pkg::*;
(
  // clock and power-on reset
  input wire logic clk,
  input wire logic nrst,
  // select fields from port_pin_io_control_reg
  input wire logic [pmx_pkg::SEL_W-1:0] sel_bit0,
  input wire logic [pmx_pkg::SEL_W-1:0] sel_bit2,
  input wire logic [pmx_pkg::SEL_W-1:0] sel_bit3,
  // internal sources
  input wire logic [pmx_pkg::NPIN-1:0] port_out,
  input wire logic timer3_toggle_out,
  input wire logic timer6_toggle_out,
  input wire logic analog_mux_ctrl0,
  input wire logic analog_mux_ctrl1,
  input wire logic serial_ch1_data_out,
  input wire logic serial_ch0_data_out,
  // hardware-owned debug data out on bit0
  input wire logic dbg_data_out,
  input wire logic dbg_data_out_en,
  // test pins
  input wire logic test_reset_pin,
  input wire logic factory_test_enable_pin,
  // pads, bit order 0,2,3; oe low drives
  input wire logic [pmx_pkg::NPIN-1:0] pad_in,
  output logic [pmx_pkg::NPIN-1:0] pad_out,
  output logic [pmx_pkg::NPIN-1:0] pad_oe_n,
  // observed inputs
  output logic error_trigger_input,
  output logic dbg_test_data_in,
  output logic dbg_test_mode_sel,
  output logic dbg_active,
  output logic dbg_reset_n,
  output logic factory_test_mode
);
  import pmx_pkg::*;

  wire [SEL_W-1:0] sel [NPIN];
  wire [3:0] src [NPIN];
  wire [NPIN-1:0] next_out;
  wire [NPIN-1:0] next_oe_n;
  logic armed;
  wire dbg_owns_bit0 = dbg_active && dbg_data_out_en;
  wire [1:0] pick0 = sel_bit0[SEL_SRC_HI:SEL_SRC_LO];
  wire [1:0] pick2 = sel_bit2[SEL_SRC_HI:SEL_SRC_LO];
  wire [1:0] pick3 = sel_bit3[SEL_SRC_HI:SEL_SRC_LO];

  assign sel[PMX_IDX_B0] = sel_bit0;
  assign sel[PMX_IDX_B2] = sel_bit2;
  assign sel[PMX_IDX_B3] = sel_bit3;
  // unlisted sources fall back to low; bit2 has only two
  assign src[PMX_IDX_B0] = {1'b0, timer6_toggle_out, timer3_toggle_out, port_out[0]};
  assign src[PMX_IDX_B2] = {2'b00, analog_mux_ctrl0, port_out[1]};
  assign src[PMX_IDX_B3] = {serial_ch0_data_out, serial_ch1_data_out, analog_mux_ctrl1,
                            port_out[2]};

  genvar i;
  generate
    for (i = 0; i < NPIN; i++) begin : g_pin
      wire en_sw = sel[i][SEL_OUT_BIT];
      wire [1:0] pick = sel[i][SEL_SRC_HI:SEL_SRC_LO];
      // debug owner wins regardless of the field
      wire hw_own = (i == PMX_IDX_B0) && dbg_owns_bit0;
      assign next_out[i] = hw_own ? dbg_data_out : src[i][pick];
      assign next_oe_n[i] = !(hw_own || en_sw);
    end
  endgenerate

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pad_out <= '0;
      pad_oe_n <= '1;
    end else begin
      pad_out <= next_out;
      pad_oe_n <= next_oe_n;
    end
  end

  // capture happens on the first edge after release, a clocked stand-in for the reset edge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed <= 1'b1;
      dbg_active <= 1'b0;
    end else begin
      armed <= 1'b0;
      if (armed) dbg_active <= test_reset_pin;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      error_trigger_input <= 1'b0;
      dbg_test_data_in <= 1'b0;
      dbg_test_mode_sel <= 1'b0;
      dbg_reset_n <= 1'b0;
      factory_test_mode <= 1'b0;
    end else begin
      error_trigger_input <= pad_in[0];
      dbg_test_data_in <= pad_in[1];
      dbg_test_mode_sel <= pad_in[2];
      dbg_reset_n <= test_reset_pin;
      factory_test_mode <= !factory_test_enable_pin;
    end
  end

  // every check except chk_debug_hold looks one edge after the inputs, since the pads are registered
  chk_debug_capture: assert property (@(posedge clk) disable iff (!nrst)
    armed
    |=> dbg_active == $past(test_reset_pin))
    else $error("debug capture wrong");
  chk_debug_hold: assert property (@(posedge clk) disable iff (!nrst)
    !armed && !$past(armed)
    |-> $stable(dbg_active))
    else $error("debug flag moved");
  chk_arm_once: assert property (@(posedge clk) disable iff (!nrst)
    armed
    |=> !armed)
    else $error("capture window reopened");

  chk_hw_override: assert property (@(posedge clk) disable iff (!nrst)
    dbg_owns_bit0
    |=> pad_out[0] == $past(dbg_data_out) && !pad_oe_n[0])
    else $error("debug owner lost bit0");
  chk_owner_bit0_only: assert property (@(posedge clk) disable iff (!nrst)
    dbg_owns_bit0 && !sel_bit2[SEL_OUT_BIT] && !sel_bit3[SEL_OUT_BIT]
    |=> pad_oe_n[1] && pad_oe_n[2])
    else $error("debug owner reached another pin");

  chk_sel_gpio: assert property (@(posedge clk) disable iff (!nrst)
    !dbg_owns_bit0 && sel_bit0[SEL_OUT_BIT] && pick0 == SRC_GPIO
    |=> pad_out[0] == $past(port_out[0]) && !pad_oe_n[0])
    else $error("bit0 gpio wrong");
  chk_sel_t3: assert property (@(posedge clk) disable iff (!nrst)
    !dbg_owns_bit0 && pick0 == SRC_ALT1
    |=> pad_out[0] == $past(timer3_toggle_out))
    else $error("bit0 timer3 wrong");
  chk_sel_t6: assert property (@(posedge clk) disable iff (!nrst)
    !dbg_owns_bit0 && pick0 == SRC_ALT2
    |=> pad_out[0] == $past(timer6_toggle_out))
    else $error("bit0 timer6 wrong");
  chk_bit0_spare: assert property (@(posedge clk) disable iff (!nrst)
    !dbg_owns_bit0 && pick0 == SRC_ALT3
    |=> !pad_out[0])
    else $error("bit0 unused source not low");
  chk_bit0_off: assert property (@(posedge clk) disable iff (!nrst)
    !dbg_owns_bit0 && !sel_bit0[SEL_OUT_BIT]
    |=> pad_oe_n[0])
    else $error("bit0 driven in input mode");
  chk_bit0_on: assert property (@(posedge clk) disable iff (!nrst)
    sel_bit0[SEL_OUT_BIT]
    |=> !pad_oe_n[0])
    else $error("bit0 released in output mode");

  chk_bit2_gpio: assert property (@(posedge clk) disable iff (!nrst)
    pick2 == SRC_GPIO
    |=> pad_out[1] == $past(port_out[1]))
    else $error("bit2 gpio wrong");
  chk_sel_mux0: assert property (@(posedge clk) disable iff (!nrst)
    pick2 == SRC_ALT1
    |=> pad_out[1] == $past(analog_mux_ctrl0))
    else $error("bit2 mux wrong");
  chk_bit2_spare: assert property (@(posedge clk) disable iff (!nrst)
    pick2 == SRC_ALT2 || pick2 == SRC_ALT3
    |=> !pad_out[1])
    else $error("bit2 unused source not low");
  chk_bit2_drive: assert property (@(posedge clk) disable iff (!nrst)
    1'b1
    |=> pad_oe_n[1] != $past(sel_bit2[SEL_OUT_BIT]))
    else $error("bit2 drive enable wrong");

  chk_bit3_gpio: assert property (@(posedge clk) disable iff (!nrst)
    pick3 == SRC_GPIO
    |=> pad_out[2] == $past(port_out[2]))
    else $error("bit3 gpio wrong");
  chk_sel_mux1: assert property (@(posedge clk) disable iff (!nrst)
    pick3 == SRC_ALT1
    |=> pad_out[2] == $past(analog_mux_ctrl1))
    else $error("bit3 mux wrong");
  chk_sel_ser1: assert property (@(posedge clk) disable iff (!nrst)
    pick3 == SRC_ALT2
    |=> pad_out[2] == $past(serial_ch1_data_out))
    else $error("bit3 serial1 wrong");
  chk_sel_ser0: assert property (@(posedge clk) disable iff (!nrst)
    pick3 == SRC_ALT3
    |=> pad_out[2] == $past(serial_ch0_data_out))
    else $error("bit3 serial0 wrong");
  chk_input_off: assert property (@(posedge clk) disable iff (!nrst)
    !sel_bit3[SEL_OUT_BIT]
    |=> pad_oe_n[2])
    else $error("bit3 driven in input mode");
  chk_output_on: assert property (@(posedge clk) disable iff (!nrst)
    sel_bit3[SEL_OUT_BIT]
    |=> !pad_oe_n[2])
    else $error("bit3 released in output mode");

  chk_err_follow: assert property (@(posedge clk) disable iff (!nrst)
    1'b1
    |=> error_trigger_input == $past(pad_in[0]))
    else $error("error trigger input lagging");
  chk_test_data_in: assert property (@(posedge clk) disable iff (!nrst)
    1'b1
    |=> dbg_test_data_in == $past(pad_in[1]))
    else $error("test data input lagging");
  chk_mode_sel_follow: assert property (@(posedge clk) disable iff (!nrst)
    1'b1
    |=> dbg_test_mode_sel == $past(pad_in[2]))
    else $error("test mode select lagging");
  chk_test_reset_follow: assert property (@(posedge clk) disable iff (!nrst)
    1'b1
    |=> dbg_reset_n == $past(test_reset_pin))
    else $error("test reset level lagging");
  chk_test_enable_follow: assert property (@(posedge clk) disable iff (!nrst)
    1'b1
    |=> factory_test_mode != $past(factory_test_enable_pin))
    else $error("factory test mode wrong");
endmodule : pmx_port7_mux

// [test/pmx_board.sv]
// board model: resolves pad levels from the block and external drivers
`timescale 1ns/100ps
module pmx_board
  import pmx_pkg::*;
(
  // block side and external drive
  input wire logic [pmx_pkg::NPIN-1:0] pad_out,
  input wire logic [pmx_pkg::NPIN-1:0] pad_oe_n,
  input wire logic [pmx_pkg::NPIN-1:0] ext,
  output logic [pmx_pkg::NPIN-1:0] pad_in
);
  // a released pad shows the external level, never the block's last value
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext);
endmodule : pmx_board

// [test/tb_pmx_port7_mux.sv]
// testbench for the port 7 output select block
`timescale 1ns/100ps
module tb_pmx_port7_mux;
  import pmx_pkg::*;
  logic clk = 0, nrst = 0, t3 = 0, t6 = 1, a0 = 0, a1 = 1, s1 = 0, s0 = 1, dd = 0, de = 0;
  logic trst = 0, tm = 1, eti, dti, dms, dact, drn, ftm;
  logic [SEL_W-1:0] b0 = 4'h0, b2 = 4'h0, b3 = 4'h0;
  logic [NPIN-1:0] po = 3'h5, pin, pout, poe, ext = 3'h2;
  int mismatches = 0, comparisons = 0;
  pmx_port7_mux dut (.clk(clk), .nrst(nrst), .sel_bit0(b0), .sel_bit2(b2), .sel_bit3(b3),
    .port_out(po), .timer3_toggle_out(t3), .timer6_toggle_out(t6), .analog_mux_ctrl0(a0),
    .analog_mux_ctrl1(a1), .serial_ch1_data_out(s1), .serial_ch0_data_out(s0),
    .dbg_data_out(dd), .dbg_data_out_en(de), .test_reset_pin(trst),
    .factory_test_enable_pin(tm), .pad_in(pin), .pad_out(pout), .pad_oe_n(poe),
    .error_trigger_input(eti), .dbg_test_data_in(dti), .dbg_test_mode_sel(dms),
    .dbg_active(dact), .dbg_reset_n(drn), .factory_test_mode(ftm));
  pmx_board board (.pad_out(pout), .pad_oe_n(poe), .ext(ext), .pad_in(pin));
  initial forever #25 clk = ~clk;
  task automatic chk(input logic [3:0] e, input logic [3:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic t_mux;
    logic [3:0] e0, e2, e3;
    for (int k = 0; k < 2; k++) begin
      e0 = {1'b0, t6, t3, po[0]};
      e2 = {2'b00, a0, po[1]};
      e3 = {s0, s1, a1, po[2]};
      for (int i = 0; i < 4; i++) begin
        b0 = 4'h8 + 4'(i);
        b2 = 4'hC + 4'(i);
        b3 = 4'h8 + 4'(i);
        cyc(1);
        chk({1'b0, e3[i], e2[i], e0[i]}, {1'b0, pout});
        chk(4'h0, {1'b0, poe});
      end
      // flip every source so no pad can match by a lucky constant level
      {t3, t6, a0, a1, s1, s0} = ~{t3, t6, a0, a1, s1, s0};
      po = ~po;
    end
    b0 = 4'h7;
    b2 = 4'h3;
    b3 = 4'h4;
    cyc(2);
    chk(4'h7, {1'b0, poe});
    chk({1'b0, ext}, {1'b0, dms, dti, eti});
    ext = 3'h5;
    cyc(2);
    chk({1'b0, ext}, {1'b0, dms, dti, eti});
    $display("test mux done");
  endtask : t_mux
  task automatic t_dbg(input logic lvl);
    trst = lvl;
    nrst = 0;
    cyc(2);
    chk(4'h7, {1'b0, poe});
    chk(4'h0, {dact, pout});
    nrst = 1;
    de = 1;
    b0 = 4'h2;
    cyc(2);
    chk({3'h0, lvl}, {3'h0, dact});
    chk({2'h0, !lvl, lvl ? dd : t6}, {2'h0, poe[0], pout[0]});
    trst = 0;
    tm = 0;
    cyc(2);
    chk(4'h1, {2'h0, drn, ftm});
    trst = 1;
    tm = 1;
    cyc(2);
    chk({1'b0, lvl, 2'h2}, {1'b0, dact, drn, ftm});
    $display("test debug done");
  endtask : t_dbg
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  initial begin
    cyc(16);
    nrst = 1;
    cyc(1);
    t_mux();
    t_dbg(1'b1);
    t_dbg(1'b0);
    conclude();
  end
endmodule : tb_pmx_port7_mux
